// ==== core/tprs_pkg.sv ====
// Package: register map, field layout, modes and carriers of the readout register block
package tprs_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_TEMP_A     = 8'h4a;
   localparam logic [7:0] OFS_TEMP_B     = 8'h4b;
   localparam logic [7:0] OFS_PIX12      = 8'h4c;
   localparam logic [7:0] OFS_SAT_TOP    = 8'h4d;
   localparam logic [7:0] OFS_SAT_BOT    = 8'h4e;
   localparam logic [7:0] OFS_OVF_TOP    = 8'h50;
   localparam logic [7:0] OFS_OVF_BOT    = 8'h51;
   localparam logic [7:0] OFS_UNF_TOP    = 8'h52;
   localparam logic [7:0] OFS_UNF_BOT    = 8'h53;
   localparam logic [7:0] OFS_SUM_DATA   = 8'h54;
   localparam logic [7:0] OFS_RD_STATUS  = 8'h55;
   localparam logic [7:0] OFS_ACQ_CTRL   = 8'h58;
   localparam logic [7:0] OFS_FINE_A     = 8'h71;
   localparam logic [7:0] OFS_FINE_B     = 8'h72;
   localparam logic [7:0] OFS_COARSE     = 8'h73;
   // ==========================================================
   // Field positions and reset value
   localparam int         BIT_RELEASE    = 0;
   localparam int         BIT_MULTI      = 1;
   localparam int         BIT_RDY        = 7;
   localparam logic [7:0] REG_RESET      = 8'h00;
   // ==========================================================
   // Delay-line limits
   localparam logic [9:0] FINE_MAX       = 10'h31f;
   localparam logic [5:0] COARSE_MAX     = 6'h31;
   // ==========================================================
   // Serial command codes and sum widths
   localparam logic [7:0] CMD_READ       = 8'h00;
   localparam logic [7:0] CMD_WRITE      = 8'h01;
   localparam int         SUM_W14        = 14;
   localparam int         SUM_W15        = 15;
   localparam int         SUM_W18        = 18;
   localparam logic [5:0] SUM_BYTES2     = 6'h02;
   localparam logic [5:0] SUM_BYTES3     = 6'h03;
   // ==========================================================
   // Operating modes
   typedef enum logic [3:0] {
      distance_imager_mode, imager_variant_mode_a, greyscale_imager_mode, greyscale_variant_mode,
      fast_four_pixel_sum_mode, sum_variant_mode_b, high_dynamic_sum_mode, sum_variant_mode_c,
      low_noise_sum_mode
   } tprs_mode_e;
   // Flag bytes of one double-row
   typedef struct packed {
      logic [7:0] sat_top;
      logic [7:0] sat_bot;
      logic [7:0] ovf_top;
      logic [7:0] ovf_bot;
      logic [7:0] unf_top;
      logic [7:0] unf_bot;
   } tprs_flags_s;
   // One double-row handed over by the core
   typedef struct packed {
      tprs_flags_s flags;
      logic [5:0]  byte_cnt;
      logic [17:0] sum_word;
      logic        side_info;
   } tprs_row_s;
endpackage : tprs_pkg

// ==== core/tprs_regs.sv ====
// Readout, shutter and delay-line registers reached over the serial port
// What this block does
// - Even/odd 12-bit pixels through one register
// - Saturation flag bytes, top and bottom
// - Overflow flag bytes, top and bottom
// - Underflow flag bytes, top and bottom
// - Finished double-row reloads flags and data
// - Sum data 14, 15 or 18 bits
// - Signed and unsigned share one format
// - Raw sum data without side information
// - Status bits 0-5 give bytes remaining
// - Status bit 7 mirrors data-ready pin
// - Single-shot release starts, then self-clears
// - Release stays set in multi-frame mode
// - Bit 1 selects multi-frame, needs release
// - Fine delay 10 ps steps, max 799
// - Coarse delay 2 ns steps, max 49
// - Delays apply only when enabled
// - All registers reset to zero
`timescale 1ns/1ps
module tprs_regs
   import tprs_pkg::*;
(
   input  wire logic        sys_clk,      // Core clock
   input  wire logic        rst_n,        // Asynchronous reset, active low
   input  wire logic        ce,           // Clock enable, freezes state when low
   input  wire logic        spi_sclk,     // Serial clock pin
   input  wire logic        spi_cs_n,     // Chip select pin, active low
   input  wire logic        spi_mosi,     // Serial data in pin
   output logic             spi_miso,     // Serial data out
   output logic             spi_miso_oe,  // Serial data out enable
   input  wire tprs_mode_e  op_mode,      // Selected operating mode
   input  wire logic        sum_raw,      // Raw sum data select
   input  wire logic        sum_signed,   // Sum data is signed
   input  wire logic        dll_en,       // Delay-line enable
   input  wire logic [15:0] temp_word,    // Temperature reading
   input  wire logic [7:0]  pix_byte,     // Current 12-bit pixel byte
   output logic             pix_ack,      // Pixel byte taken, pulse
   input  wire logic        row_load,     // New double-row present, pulse
   input  wire tprs_row_s   row_in,       // Double-row contents
   output logic             row_req,      // Next double-row wanted, pulse
   input  wire logic        frame_done,   // Acquisition finished, pulse
   output logic             acq_start,    // Start acquisition, pulse
   output logic             multi_run,    // Continuous acquisition active
   output logic             data_rdy,     // Data ready pin
   output logic [9:0]       dly_fine,     // Effective fine delay steps
   output logic [5:0]       dly_coarse    // Effective coarse delay steps
);
   // ==========================================================
   // Functions
   // Bit width of the sum result for a mode
   function automatic int sum_width(input tprs_mode_e m);
      case (m)
         fast_four_pixel_sum_mode, sum_variant_mode_b: sum_width = SUM_W14;
         high_dynamic_sum_mode, sum_variant_mode_c:    sum_width = SUM_W15;
         default:                                      sum_width = SUM_W18;
      endcase
   endfunction : sum_width

   // Format a sum word into a right-aligned byte stream
   function automatic logic [23:0] fmt_sum(input logic [17:0] w, input tprs_mode_e m,
                                           input logic sgn, input logic raw, input logic side);
      int          wd;
      int          top;
      logic [23:0] r;
      wd  = sum_width(m);
      top = (wd > 16) ? 23 : 15;
      r   = 24'h000000;
      for (int i = 0; i < 24; i++) begin
         if (i < wd) begin
            r[i] = w[i];
         end else if (i <= top) begin
            r[i] = sgn & w[wd-1];
         end
      end
      if (!raw) begin
         r[top] = side;
      end
      fmt_sum = r;
   endfunction : fmt_sum

   // True for the four 12-bit image modes
   function automatic logic is_img12(input tprs_mode_e m);
      is_img12 = (m == distance_imager_mode) || (m == imager_variant_mode_a) ||
                 (m == greyscale_imager_mode) || (m == greyscale_variant_mode);
   endfunction : is_img12

   // ==========================================================
   // Pin synchronisers
   logic [2:0] sclk_s_r;        // Serial clock: two sync stages and history
   logic [1:0] cs_s_r;          // Chip select sync stages
   logic [1:0] mosi_s_r;        // Data in sync stages

   // Two sync flip-flops per pin, plus a history stage on the serial clock; stage one feeds only stage two
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s_r <= 3'h0;
         cs_s_r   <= 2'h3;
         mosi_s_r <= 2'h0;
      end else if (ce) begin
         sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
         cs_s_r   <= {cs_s_r[0], spi_cs_n};
         mosi_s_r <= {mosi_s_r[0], spi_mosi};
      end
   end

   wire sel_w  = !cs_s_r[1];                                // Frame active
   wire rise_w = sel_w && sclk_s_r[1] && !sclk_s_r[2];      // Sample edge
   wire fall_w = sel_w && !sclk_s_r[1] && sclk_s_r[2];      // Shift-out edge
   wire mosi_w = mosi_s_r[1];                               // Synced data in

   // ==========================================================
   // Serial state
   logic [2:0] bit_cnt_r;       // Bit within byte
   logic [1:0] byte_idx_r;      // Byte within frame, saturates at 2
   logic [7:0] rx_r;            // Incoming shift register
   logic [7:0] cmd_r;           // Command byte
   logic [7:0] addr_r;          // Register address
   logic [7:0] tx_r;            // Outgoing shift register

   wire [7:0] rx_byte_w  = {rx_r[6:0], mosi_w};              // Byte being completed
   wire       byte_end_w = rise_w && (bit_cnt_r == 3'h7);    // Last bit sampled
   wire       addr_end_w = byte_end_w && (byte_idx_r == 2'h1);
   wire       data_end_w = byte_end_w && (byte_idx_r == 2'h2);
   wire       is_write_w = (cmd_r == CMD_WRITE);
   wire       is_read_w  = (cmd_r == CMD_READ);
   wire [7:0] rd_addr_w  = (byte_idx_r == 2'h1) ? rx_byte_w : addr_r;
   // A read is served at the end of the address byte and of every later byte
   wire       rd_stb_w   = is_read_w && (addr_end_w || data_end_w);
   wire       wr_stb_w   = is_write_w && data_end_w;

   // ==========================================================
   // Registers
   tprs_flags_s flags_r;        // Flag bytes of the current double-row
   logic [5:0]  cnt_r;          // Bytes remaining in the double-row
   logic [23:0] sum_r;          // Formatted sum bytes
   logic        rdy_r;          // Data ready
   logic        release_r;      // Shutter release
   logic        multi_r;        // Multiple-frame select
   logic [7:0]  fine_a_r;       // Fine steps, low byte
   logic [1:0]  fine_b_r;       // Fine steps, high bits
   logic [5:0]  coarse_r;       // Coarse steps

   // ==========================================================
   // Read data and side effects
   wire        sum_mode_w = !is_img12(op_mode);                       // Sum modes use 0x54
   wire [7:0]  active_w   = sum_mode_w ? OFS_SUM_DATA : OFS_PIX12;     // Active data register
   wire [5:0]  sum_n_w    = (sum_width(op_mode) > 16) ? SUM_BYTES3 : SUM_BYTES2;
   // pick the sum byte, most significant first
   wire [7:0]  sum_byte_w = (cnt_r == 6'h3) ? sum_r[23:16] :
                            (cnt_r == 6'h2) ? sum_r[15:8]  : sum_r[7:0];
   wire [7:0]  status_w;        // Readout status byte
   // remaining byte count in the low bits
   assign status_w = {rdy_r, 1'b0, cnt_r};
   // a read of the active data register consumes a byte
   wire        consume_w = rd_stb_w && (rd_addr_w == active_w) && (cnt_r != 6'h00);
   wire        last_w    = consume_w && (cnt_r == 6'h01);

   logic [7:0] rd_data_w;       // Read multiplexer
   // Select the value of the addressed register
   always_comb begin
      case (rd_addr_w)
         // temperature is only valid after the image read
         OFS_TEMP_A:    rd_data_w = temp_word[15:8];
         OFS_TEMP_B:    rd_data_w = temp_word[7:0];
         // even then odd pixel bytes through one register
         OFS_PIX12:     rd_data_w = (!sum_mode_w && cnt_r != 6'h00) ? pix_byte : REG_RESET;
         // saturation flags, bit n is column n
         OFS_SAT_TOP:   rd_data_w = flags_r.sat_top;
         OFS_SAT_BOT:   rd_data_w = flags_r.sat_bot;
         OFS_OVF_TOP:   rd_data_w = flags_r.ovf_top;
         OFS_OVF_BOT:   rd_data_w = flags_r.ovf_bot;
         OFS_UNF_TOP:   rd_data_w = flags_r.unf_top;
         OFS_UNF_BOT:   rd_data_w = flags_r.unf_bot;
         OFS_SUM_DATA:  rd_data_w = (sum_mode_w && cnt_r != 6'h00) ? sum_byte_w : REG_RESET;
         OFS_RD_STATUS: rd_data_w = status_w;
         OFS_ACQ_CTRL:  rd_data_w = {6'h00, multi_r, release_r};
         OFS_FINE_A:    rd_data_w = fine_a_r;
         OFS_FINE_B:    rd_data_w = {6'h00, fine_b_r};
         OFS_COARSE:    rd_data_w = {2'h0, coarse_r};
         default:       rd_data_w = REG_RESET;
      endcase
   end

   // ==========================================================
   // Write decode
   wire wr_acq_w    = wr_stb_w && (addr_r == OFS_ACQ_CTRL);
   wire wr_fine_a_w = wr_stb_w && (addr_r == OFS_FINE_A);
   wire wr_fine_b_w = wr_stb_w && (addr_r == OFS_FINE_B);
   wire wr_coarse_w = wr_stb_w && (addr_r == OFS_COARSE);
   // fine count held across two registers, limited to 799
   wire [9:0] fine_w   = {fine_b_r, fine_a_r};
   wire [9:0] fine_c_w = (fine_w > FINE_MAX) ? FINE_MAX : fine_w;
   wire [5:0] coarse_c_w = (coarse_r > COARSE_MAX) ? COARSE_MAX : coarse_r;
   // continuous mode only while release is set
   wire       run_w = release_r && multi_r;
   // another frame follows a finished one while running
   wire       restart_w = run_w && frame_done && !wr_acq_w;

   // ==========================================================
   // Serial shift logic
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_r  <= 3'h0;
         byte_idx_r <= 2'h0;
         rx_r       <= REG_RESET;
         cmd_r      <= REG_RESET;
         addr_r     <= REG_RESET;
      end else if (ce) begin
         if (!sel_w) begin
            // Idle between frames
            bit_cnt_r  <= 3'h0;
            byte_idx_r <= 2'h0;
         end else if (rise_w) begin
            // Sample one bit, most significant first
            rx_r      <= rx_byte_w;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_end_w) begin
               if (byte_idx_r == 2'h0) begin
                  cmd_r <= rx_byte_w;
               end
               if (byte_idx_r == 2'h1) begin
                  addr_r <= rx_byte_w;
               end
               if (byte_idx_r != 2'h2) begin
                  byte_idx_r <= byte_idx_r + 2'h1;
               end
            end
         end
      end
   end

   // Output shifting: load on read, shift on falling edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_r        <= REG_RESET;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else if (ce) begin
         spi_miso_oe <= sel_w;
         if (!sel_w) begin
            tx_r     <= REG_RESET;
            spi_miso <= 1'b0;
         end else if (rd_stb_w) begin
            tx_r <= rd_data_w;
         end else if (fall_w) begin
            spi_miso <= tx_r[7];
            tx_r     <= {tx_r[6:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // Double-row buffers and ready
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= '0;
         cnt_r   <= 6'h00;
         sum_r   <= 24'h000000;
         rdy_r   <= 1'b0;
         row_req <= 1'b0;
         pix_ack <= 1'b0;
      end else if (ce) begin
         pix_ack <= consume_w && !sum_mode_w;
         row_req <= last_w;
         if (row_load) begin
            // new double-row replaces flags and data
            flags_r <= row_in.flags;
            // raw form drops the side bit
            sum_r   <= fmt_sum(row_in.sum_word, op_mode, sum_signed, sum_raw, row_in.side_info);
            cnt_r   <= sum_mode_w ? sum_n_w : row_in.byte_cnt;
            rdy_r   <= 1'b1;
         end else if (consume_w) begin
            // count down, ready drops at zero
            cnt_r <= cnt_r - 6'h01;
            if (last_w) begin
               rdy_r <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Shutter control
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         release_r <= 1'b0;
         multi_r   <= 1'b0;
         acq_start <= 1'b0;
      end else if (ce) begin
         acq_start <= 1'b0;
         if (wr_acq_w) begin
            multi_r   <= rx_byte_w[BIT_MULTI];
            release_r <= rx_byte_w[BIT_RELEASE];
            acq_start <= rx_byte_w[BIT_RELEASE];
         end else if (release_r && !multi_r) begin
            release_r <= 1'b0;
         end else if (restart_w) begin
            acq_start <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Delay-line registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fine_a_r <= REG_RESET;
         fine_b_r <= 2'h0;
         coarse_r <= 6'h00;
      end else if (ce) begin
         if (wr_fine_a_w) begin
            fine_a_r <= rx_byte_w;
         end
         if (wr_fine_b_w) begin
            fine_b_r <= rx_byte_w[1:0];
         end
         if (wr_coarse_w) begin
            coarse_r <= rx_byte_w[5:0];
         end
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_rdy   <= 1'b0;
         multi_run  <= 1'b0;
         dly_fine   <= 10'h000;
         dly_coarse <= 6'h00;
      end else if (ce) begin
         data_rdy   <= rdy_r;
         multi_run  <= run_w;
         dly_fine   <= dll_en ? fine_c_w : 10'h000;
         dly_coarse <= dll_en ? coarse_c_w : 6'h00;
      end
   end

endmodule : tprs_regs

// ==== tb/tof_pixel_readout_shutter_regs_tb.sv ====
// Testbench: registers, readout, shutter, delays
`timescale 1ns/1ps
module tof_pixel_readout_shutter_regs_tb;
   import tprs_pkg::*;
   // ====
   // Stimulus and observed signals
   logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, dll_en = 1'b0, sum_raw = 1'b1, sum_signed = 1'b0;
   logic row_load = 1'b0, frame_done = 1'b0;
   logic [15:0] temp_word = 16'h0000;
   logic [7:0] pix_byte = 8'h5a;
   tprs_mode_e op_mode = distance_imager_mode;
   tprs_row_s row_in = '0;
   wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, pix_ack, row_req, acq_start, multi_run, data_rdy;
   wire [9:0] dly_fine;
   wire [5:0] dly_coarse;
   wire miso_line = spi_miso_oe ? spi_miso : 1'bz; // Level the host sees
   int miscompares = 0, check_count = 0, cycles = 0, acq_cnt = 0, req_cnt = 0;
   logic [23:0] rd_v;
   // Register accesses: address, write, data or expected read
   typedef struct packed { logic [7:0] a; logic wr; logic [7:0] d; } tprs_tb_row_s;
   localparam tprs_tb_row_s ROWS [22] = '{
      '{8'h4c, 1'b0, 8'h00}, '{8'h4d, 1'b0, 8'h00}, '{8'h4e, 1'b0, 8'h00}, '{8'h50, 1'b0, 8'h00},
      '{8'h51, 1'b0, 8'h00}, '{8'h52, 1'b0, 8'h00}, '{8'h53, 1'b0, 8'h00}, '{8'h54, 1'b0, 8'h00},
      '{8'h55, 1'b0, 8'h00}, '{8'h58, 1'b0, 8'h00}, '{8'h71, 1'b0, 8'h00}, '{8'h72, 1'b0, 8'h00},
      '{8'h73, 1'b0, 8'h00}, '{8'h4f, 1'b0, 8'h00}, '{8'h55, 1'b1, 8'hff}, '{8'h55, 1'b0, 8'h00},
      '{8'h71, 1'b1, 8'h1f}, '{8'h72, 1'b1, 8'h03}, '{8'h73, 1'b1, 8'h31}, '{8'h71, 1'b0, 8'h1f},
      '{8'h72, 1'b0, 8'h03}, '{8'h73, 1'b0, 8'h31}};
   // Sum modes: mode, width, signed, raw, value
   typedef struct packed { tprs_mode_e m; int w; logic sg; logic raw; logic [17:0] v; } tprs_tb_sum_s;
   localparam tprs_tb_sum_s SUMS [5] = '{
      '{fast_four_pixel_sum_mode, SUM_W14, 1'b0, 1'b1, 18'h2abcd}, '{sum_variant_mode_b, SUM_W14, 1'b1, 1'b0, 18'h2abcd},
      '{high_dynamic_sum_mode, SUM_W15, 1'b1, 1'b1, 18'h04321}, '{sum_variant_mode_c, SUM_W15, 1'b0, 1'b0, 18'h04321},
      '{low_noise_sum_mode, SUM_W18, 1'b1, 1'b0, 18'h2abcd}};
   tprs_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .op_mode(op_mode), .sum_raw(sum_raw),
      .sum_signed(sum_signed), .dll_en(dll_en), .temp_word(temp_word), .pix_byte(pix_byte), .pix_ack(pix_ack),
      .row_load(row_load), .row_in(row_in), .row_req(row_req), .frame_done(frame_done), .acq_start(acq_start),
      .multi_run(multi_run), .data_rdy(data_rdy), .dly_fine(dly_fine), .dly_coarse(dly_coarse));
   tprs_host_model u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(miso_line));
   // ====
   // Clock, core-side responses and run limit
   always #4 sys_clk = ~sys_clk;
   always @(negedge sys_clk) begin
      cycles <= cycles + 1;
      if (pix_ack) pix_byte <= pix_byte + 8'h11;
      if (acq_start) acq_cnt <= acq_cnt + 1;
      if (row_req) req_cnt <= req_cnt + 1;
      if (cycles == 60000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : settle
   task automatic rd(input logic [7:0] a, input int nb, input logic [23:0] exp);
      u_host.xfer(CMD_READ, a, 24'h000000, nb, rd_v);
      settle(4);
      chk($sformatf("reg %h", a), exp, rd_v);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.xfer(CMD_WRITE, a, {16'h0000, d}, 1, rd_v);
      settle(4);
   endtask : wr
   // Core hands over one double-row
   task automatic load(input logic [47:0] fl, input logic [5:0] cnt, input logic [17:0] sw, input logic side);
      row_in = {fl, cnt, sw, side};
      row_load = 1'b1;
      settle(1);
      row_load = 1'b0;
      settle(4);
   endtask : load
   // Expected sum bytes, by the rules
   function automatic logic [23:0] sum_exp(input tprs_tb_sum_s s, input int nb);
      logic [23:0] r;
      r = {6'h00, s.v} & ((24'h1 << s.w) - 24'h1);
      if (s.sg && s.v[s.w - 1]) r = r | ~((24'h1 << s.w) - 24'h1);
      r = r & ((24'h1 << (8 * nb)) - 24'h1);
      if (!s.raw) r[8 * nb - 1] = 1'b1;
      return r;
   endfunction : sum_exp
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // ====
   // Main sequence
   initial begin
      settle(2);
      rst_n = 1'b1;
      settle(4);
      foreach (ROWS[i]) begin
         if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d);
         else rd(ROWS[i].a, 1, {16'h0000, ROWS[i].d});
      end
      chk("dly_fine", 24'h0, {14'h0, dly_fine});
      dll_en = 1'b1;
      settle(3);
      chk("dly_fine", {14'h0, FINE_MAX}, {14'h0, dly_fine});
      chk("dly_coarse", {18'h0, COARSE_MAX}, {18'h0, dly_coarse});
      wr(OFS_FINE_A, 8'h20);
      wr(OFS_COARSE, 8'h32);
      chk("dly_fine", {14'h0, FINE_MAX}, {14'h0, dly_fine});
      chk("dly_coarse", {18'h0, COARSE_MAX}, {18'h0, dly_coarse});
      load(48'h8142_2418_0180, 6'h03, 18'h00000, 1'b0);
      chk("data_rdy", 24'h1, {23'h0, data_rdy});
      rd(OFS_RD_STATUS, 1, 24'h000083);
      rd(OFS_SAT_TOP, 1, 24'h000081);
      rd(OFS_SAT_BOT, 1, 24'h000042);
      rd(OFS_OVF_TOP, 1, 24'h000024);
      rd(OFS_OVF_BOT, 1, 24'h000018);
      rd(OFS_UNF_TOP, 1, 24'h000001);
      rd(OFS_UNF_BOT, 1, 24'h000080);
      rd(OFS_PIX12, 3, 24'h5a6b7c);
      chk("data_rdy", 24'h0, {23'h0, data_rdy});
      chk("row_req", 24'h1, req_cnt[23:0]);
      rd(OFS_RD_STATUS, 1, 24'h000000);
      rd(OFS_PIX12, 1, 24'h000000);
      chk("pix_byte", 24'h8d, {16'h0, pix_byte});
      load(48'hff00_0000_0000, 6'h02, 18'h00000, 1'b0);
      rd(OFS_SAT_TOP, 1, 24'h0000ff);
      for (int m = 0; m < 4; m++) begin
         op_mode = tprs_mode_e'(m);
         load(48'h0, 6'h01, 18'h00000, 1'b0);
         rd(OFS_PIX12, 1, {16'h0, 8'h8d + 8'h11 * m[7:0]});
      end
      temp_word = 16'ha5c3;
      settle(2);
      rd(OFS_TEMP_A, 1, 24'h0000a5);
      rd(OFS_TEMP_B, 1, 24'h0000c3);
      foreach (SUMS[i]) begin
         op_mode = SUMS[i].m;
         sum_signed = SUMS[i].sg;
         sum_raw = SUMS[i].raw;
         load(48'h0, 6'h00, SUMS[i].v, 1'b1);
         rd(OFS_SUM_DATA, (SUMS[i].w == SUM_W18) ? 3 : 2, sum_exp(SUMS[i], (SUMS[i].w == SUM_W18) ? 3 : 2));
         chk("data_rdy", 24'h0, {23'h0, data_rdy});
      end
      wr(OFS_ACQ_CTRL, 8'h01);
      rd(OFS_ACQ_CTRL, 1, 24'h000000);
      chk("acq_cnt", 24'h1, acq_cnt[23:0]);
      wr(OFS_ACQ_CTRL, 8'h03);
      rd(OFS_ACQ_CTRL, 1, 24'h000003);
      chk("multi_run", 24'h1, {23'h0, multi_run});
      repeat (2) begin
         frame_done = 1'b1;
         settle(1);
         frame_done = 1'b0;
         settle(4);
      end
      chk("acq_cnt", 24'h4, acq_cnt[23:0]);
      wr(OFS_ACQ_CTRL, 8'h02);
      chk("multi_run", 24'h0, {23'h0, multi_run});
      ce = 1'b0;
      dll_en = 1'b0;
      settle(2);
      chk("frozen", {14'h0, FINE_MAX}, {14'h0, dly_fine});
      ce = 1'b1;
      rst_n = 1'b0;
      settle(2);
      chk("dly_fine", 24'h0, {14'h0, dly_fine});
      rst_n = 1'b1;
      settle(4);
      rd(OFS_FINE_B, 1, 24'h000000);
      rd(OFS_ACQ_CTRL, 1, 24'h000000);
      tally_and_finish();
   end
endmodule : tof_pixel_readout_shutter_regs_tb

// ==== tb/tprs_host_model.sv ====
// Host model: serial master, mode 0
`timescale 1ns/1ps
module tprs_host_model (
   output logic      spi_sclk, // Serial clock
   output logic      spi_cs_n, // Chip select, active low
   output logic      spi_mosi, // Data to device
   input  wire logic spi_miso  // Data from device
);
   // ====
   // Idle pins at time zero
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // One frame: command, address, nb data bytes, MSB first
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input logic [23:0] wdat,
                       input int nb, output logic [23:0] rdat);
      logic [39:0] tx;
      logic [39:0] rx;
      tx = {cmd, addr, wdat << (8 * (3 - nb))};
      rx = '0;
      #1.3;
      spi_cs_n = 1'b0;
      for (int i = 0; i < 16 + 8 * nb; i++) begin
         spi_mosi = tx[39 - i];
         #80;
         spi_sclk = 1'b1;
         rx = {rx[38:0], spi_miso};
         #80;
         spi_sclk = 1'b0;
      end
      #80;
      spi_cs_n = 1'b1;
      // Released line shows the opposite of its last bit
      spi_mosi = ~spi_mosi;
      rdat = rx[23:0] & ((24'h1 << (8 * nb)) - 24'h1);
   endtask : xfer
endmodule : tprs_host_model

// ==== tb/tprs_regs_asserts.sv ====
// Port-level assertions for the readout register block
`timescale 1ns/1ps
module tprs_regs_asserts
   import tprs_pkg::*;
(
   input wire logic       sys_clk,    // Core clock
   input wire logic       rst_n,      // Reset, active low
   input wire logic       ce,         // Clock enable
   input wire tprs_mode_e op_mode,    // Operating mode
   input wire logic       dll_en,     // Delay enable
   input wire logic       pix_ack,    // Pixel byte taken
   input wire logic       row_load,   // Row present
   input wire tprs_row_s  row_in,     // Row contents
   input wire logic       row_req,    // Row wanted
   input wire logic       frame_done, // Frame finished
   input wire logic       acq_start,  // Start pulse
   input wire logic       multi_run,  // Continuous run
   input wire logic       data_rdy,   // Data ready
   input wire logic [9:0] dly_fine,   // Fine delay
   input wire logic [5:0] dly_coarse  // Coarse delay
);
   // ====
   // Common clock and reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // Sum modes set their own byte count
   wire is_sum = (op_mode >= fast_four_pixel_sum_mode);
   // ====
   // Assertions
   chk_reset_zero: assert property (disable iff (1'b0)
      !rst_n |-> !acq_start && !multi_run && !data_rdy && dly_fine == 10'h000 && dly_coarse == 6'h00)
      else $error("outputs not clear in reset");
   chk_fine_max: assert property (dly_fine <= FINE_MAX)
      else $error("fine delay above limit");
   chk_coarse_max: assert property (dly_coarse <= COARSE_MAX)
      else $error("coarse delay above limit");
   chk_delay_gate: assert property ((!dll_en && ce) [*2] |-> dly_fine == 10'h000 && dly_coarse == 6'h00)
      else $error("delay applied while disabled");
   chk_ack_pulse: assert property (pix_ack |-> !is_sum ##1 !pix_ack)
      else $error("pixel acknowledge wrong");
   chk_start_pulse: assert property (acq_start |=> !acq_start)
      else $error("start pulse too long");
   chk_multi_restart: assert property (multi_run && frame_done |-> ##[1:2] acq_start)
      else $error("no restart after frame");
   chk_load_ready: assert property (
      row_load && (is_sum || row_in.byte_cnt != 6'h00) |-> ##[1:3] data_rdy)
      else $error("ready not raised after load");
   chk_last_read: assert property (row_req ##1 !row_load |-> ##[0:3] !data_rdy)
      else $error("ready kept after last byte");
   // Main scenarios reached
   cov_row_done: cover property (row_req);
   cov_restart: cover property (multi_run && frame_done);
   cov_pixel: cover property (pix_ack);
endmodule : tprs_regs_asserts

bind tprs_regs tprs_regs_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .op_mode(op_mode),
   .dll_en(dll_en), .pix_ack(pix_ack), .row_load(row_load), .row_in(row_in), .row_req(row_req),
   .frame_done(frame_done), .acq_start(acq_start), .multi_run(multi_run), .data_rdy(data_rdy),
   .dly_fine(dly_fine), .dly_coarse(dly_coarse));
